// >>> inc/csm_pkg.sv
// Purpose: Constants for the clocked serial master channel
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: Upper 16 bits of every register read as zero

package csm_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [4:0] CSM_OFS_MODE = 5'h00;
    localparam logic [4:0] CSM_OFS_SETUP = 5'h04;
    localparam logic [4:0] CSM_OFS_DATA = 5'h08;
    localparam logic [4:0] CSM_OFS_OUTLVL = 5'h0C;
    localparam logic [4:0] CSM_OFS_START = 5'h10;
    localparam logic [4:0] CSM_OFS_STOP = 5'h14;
    localparam logic [4:0] CSM_OFS_STAT = 5'h18;
    localparam logic [4:0] CSM_OFS_PRE = 5'h1C;
    localparam logic [4:0] CSM_OFS_OEN = 5'h20;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CSM_B_OPSEL = 15;
    localparam int CSM_B_ISRC = 0;
    localparam int CSM_B_TXE = 15;
    localparam int CSM_B_RXE = 14;
    localparam int CSM_B_DAP = 13;
    localparam int CSM_B_CKP = 12;
    localparam int CSM_B_DIR = 7;
    localparam int CSM_B_DLS = 0;
    localparam int CSM_B_DIV_LO = 9;
    localparam int CSM_B_CKO = 8;
    localparam int CSM_B_SO = 0;
    localparam int CSM_B_CH = 0;
    localparam int CSM_B_OVF_CLR = 2;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] CSM_RST_PRE = 8'h00;
    localparam logic [7:0] CSM_RST_DATA = 8'h00;
    localparam logic CSM_RST_CKO = 1'h1;
    localparam logic CSM_RST_SO = 1'h1;
    // ----------------------------------------
    // Last half-period index per word
    // ----------------------------------------
    localparam logic [4:0] CSM_LAST_7 = 5'h0D;
    localparam logic [4:0] CSM_LAST_8 = 5'h0F;

    typedef enum logic [1:0] {
        CSM_IDLE = 2'h1,
        CSM_SHIFT = 2'h2
    } csm_state_t;
endpackage

// >>> hdl/csm_channel.sv
// Purpose: One clocked serial master channel, receive and transmit/receive
// Assumes: Inputs synchronous to mclk; Avalon-MM slave with waitrequest
// Notes: Prescaler, divider and serial clock are enables of mclk only
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.

`timescale 1ns/1ps
`default_nettype none

// Contract
// - Receive mode drives clock, samples input only
// - Transmit/receive shifts out and in together
// - Mode bit picks transfer-end or buffer-empty interrupt
// - Only receive overrun is flagged
// - Length bit picks seven or eight bits
// - Direction bit picks MSB or LSB first
// - Clock-select bit picks prescaler clock A or B
// - Data register upper bits set clock division
// - Phase bit adds half-period data lead
// - Polarity bit inverts the serial clock
// - Writing low byte starts word; dummy FFH
// - Low byte is data, upper bits divider
// - Mode bit may change during operation
// - New write replaces pending transmit data
module csm_channel
    import csm_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic serial_clock_pin,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_en,
    output logic channel_transfer_irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic pre_tick(input logic [15:0] cnt, input logic [3:0] e);
        logic [15:0] m;
        m = (16'h0001 << e) - 16'h0001;
        return (cnt & m) == m;
    endfunction

    function automatic logic [4:0] last_ph(input logic dls, input logic dap);
        logic [4:0] b;
        b = dls ? CSM_LAST_8 : CSM_LAST_7;
        return b + {4'h0, dap};
    endfunction

    function automatic logic [7:0] fix_rx(input logic [7:0] r, input logic dls,
                                          input logic dir);
        logic [7:0] v;
        v = r;
        if (!dls) begin
            v = dir ? {1'h0, r[7:1]} : {1'h0, r[6:0]};
        end
        return v;
    endfunction

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic ack_reg;
    logic wr_en;
    logic [31:0] rd_next;
    logic [4:0] addr;
    assign addr = avs_address[4:0];
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_en = avs_write & ack_reg;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_reg <= 1'h0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic opsel_reg, isrc_reg;
    logic txe_reg, rxe_reg, dap_reg, ckp_reg, dir_reg, dls_reg;
    logic [6:0] div_reg;
    logic cko_reg, so_reg, soe_reg, en_reg;
    logic [7:0] pre_reg;
    logic wr_lo, wr_hi;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] o,
                                 input logic w, input logic be);
        return w && be && (a == o);
    endfunction

    assign wr_lo = hit(addr, CSM_OFS_DATA, wr_en, avs_byteenable[0]);
    assign wr_hi = hit(addr, CSM_OFS_DATA, wr_en, avs_byteenable[1]);

    always_ff @(posedge mclk) begin
        if (srst) begin
            opsel_reg <= 1'h0;
            isrc_reg <= 1'h0;
        end else begin
            if (hit(addr, CSM_OFS_MODE, wr_en, avs_byteenable[1])) begin
                opsel_reg <= avs_writedata[CSM_B_OPSEL];
            end
            if (hit(addr, CSM_OFS_MODE, wr_en, avs_byteenable[0])) begin
                isrc_reg <= avs_writedata[CSM_B_ISRC];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            txe_reg <= 1'h0;
            rxe_reg <= 1'h0;
            dap_reg <= 1'h0;
            ckp_reg <= 1'h0;
            dir_reg <= 1'h0;
            dls_reg <= 1'h0;
        end else begin
            if (hit(addr, CSM_OFS_SETUP, wr_en, avs_byteenable[1])) begin
                txe_reg <= avs_writedata[CSM_B_TXE];
                rxe_reg <= avs_writedata[CSM_B_RXE];
                dap_reg <= avs_writedata[CSM_B_DAP];
                ckp_reg <= avs_writedata[CSM_B_CKP];
            end
            if (hit(addr, CSM_OFS_SETUP, wr_en, avs_byteenable[0])) begin
                dir_reg <= avs_writedata[CSM_B_DIR];
                dls_reg <= avs_writedata[CSM_B_DLS];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            div_reg <= 7'h00;
            cko_reg <= CSM_RST_CKO;
            so_reg <= CSM_RST_SO;
            soe_reg <= 1'h0;
            pre_reg <= CSM_RST_PRE;
        end else begin
            if (wr_hi) begin
                div_reg <= avs_writedata[15:CSM_B_DIV_LO];
            end
            if (hit(addr, CSM_OFS_OUTLVL, wr_en, avs_byteenable[1])) begin
                cko_reg <= avs_writedata[CSM_B_CKO];
            end
            if (hit(addr, CSM_OFS_OUTLVL, wr_en, avs_byteenable[0])) begin
                so_reg <= avs_writedata[CSM_B_SO];
            end
            if (hit(addr, CSM_OFS_OEN, wr_en, avs_byteenable[0])) begin
                soe_reg <= avs_writedata[CSM_B_CH];
            end
            if (hit(addr, CSM_OFS_PRE, wr_en, avs_byteenable[0])) begin
                pre_reg <= avs_writedata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Prescaler and divider enables
    // ----------------------------------------
    logic [15:0] pre_cnt_reg;
    logic op_tick, half_end;
    logic [6:0] dcnt_reg;
    csm_state_t state_reg;
    logic [4:0] ph_reg;
    logic load, done;

    // Both prescaler outputs share one counter so their edges align
    assign op_tick = opsel_reg ? pre_tick(pre_cnt_reg, pre_reg[7:4])
                               : pre_tick(pre_cnt_reg, pre_reg[3:0]);
    assign half_end = (state_reg == CSM_SHIFT) && op_tick && (dcnt_reg == div_reg);

    always_ff @(posedge mclk) begin
        if (srst) begin
            pre_cnt_reg <= 16'h0000;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || load) begin
            dcnt_reg <= 7'h00;
        end else if (op_tick) begin
            dcnt_reg <= (dcnt_reg == div_reg) ? 7'h00 : dcnt_reg + 7'h01;
        end
    end

    // ----------------------------------------
    // Transfer sequencing
    // ----------------------------------------
    logic [7:0] tx_buf_reg, tx_sh_reg, rx_sh_reg, rx_data_reg;
    logic bff_reg, unread_reg, ovf_reg, irq_reg;
    logic stop_wr, start_wr, rd_data, ovf_clr, sample, shift_out;

    assign stop_wr = hit(addr, CSM_OFS_STOP, wr_en, avs_byteenable[0])
                     && avs_writedata[CSM_B_CH];
    assign start_wr = hit(addr, CSM_OFS_START, wr_en, avs_byteenable[0])
                      && avs_writedata[CSM_B_CH];
    assign rd_data = avs_read && ack_reg && (addr == CSM_OFS_DATA);
    assign ovf_clr = hit(addr, CSM_OFS_STAT, wr_en, avs_byteenable[0])
                     && avs_writedata[CSM_B_OVF_CLR];
    assign done = half_end && (ph_reg == last_ph(dls_reg, dap_reg));
    // Next word starts right after the last so continuous mode has no gap
    assign load = en_reg && bff_reg && !stop_wr && ((state_reg == CSM_IDLE) || done);
    assign sample = half_end && !ph_reg[0];
    assign shift_out = half_end && ph_reg[0] && !done;

    always_ff @(posedge mclk) begin
        if (srst || stop_wr) begin
            en_reg <= 1'h0;
        end else if (start_wr) begin
            en_reg <= 1'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || stop_wr) begin
            state_reg <= CSM_IDLE;
            ph_reg <= 5'h00;
        end else if (load) begin
            state_reg <= CSM_SHIFT;
            ph_reg <= 5'h00;
        end else begin
            case (state_reg)
                CSM_IDLE: begin
                    ph_reg <= 5'h00;
                end
                CSM_SHIFT: begin
                    if (done) begin
                        state_reg <= CSM_IDLE;
                    end else if (half_end) begin
                        ph_reg <= ph_reg + 5'h01;
                    end
                end
                default: begin
                    state_reg <= CSM_IDLE;
                end
            endcase
        end
    end

    // Pending byte: a write always wins over the load that empties it
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_buf_reg <= CSM_RST_DATA;
            bff_reg <= 1'h0;
        end else if (wr_lo) begin
            tx_buf_reg <= avs_writedata[7:0];
            bff_reg <= 1'h1;
        end else if (load || stop_wr) begin
            bff_reg <= 1'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_sh_reg <= 8'h00;
        end else if (load) begin
            tx_sh_reg <= tx_buf_reg;
        end else if (shift_out) begin
            tx_sh_reg <= dir_reg ? {1'h0, tx_sh_reg[7:1]}
                                 : {tx_sh_reg[6:0], 1'h0};
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || load) begin
            rx_sh_reg <= 8'h00;
        end else if (sample) begin
            rx_sh_reg <= dir_reg ? {serial_in_pin, rx_sh_reg[7:1]}
                                 : {rx_sh_reg[6:0], serial_in_pin};
        end
    end

    // Receive side; overrun set beats a same-cycle clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_data_reg <= CSM_RST_DATA;
            unread_reg <= 1'h0;
            ovf_reg <= 1'h0;
        end else begin
            if (done && rxe_reg) begin
                rx_data_reg <= fix_rx(rx_sh_reg, dls_reg, dir_reg);
                unread_reg <= 1'h1;
            end else if (rd_data) begin
                unread_reg <= 1'h0;
            end
            if (done && rxe_reg && unread_reg && !rd_data) begin
                ovf_reg <= 1'h1;
            end else if (ovf_clr) begin
                ovf_reg <= 1'h0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_reg <= 1'h0;
        end else begin
            irq_reg <= (done && !isrc_reg) || (load && isrc_reg);
        end
    end

    // ----------------------------------------
    // Pins and read data
    // ----------------------------------------
    logic active, out_bit;
    assign active = (state_reg == CSM_SHIFT) && (ph_reg[0] == dap_reg);
    assign out_bit = dir_reg ? tx_sh_reg[0] : (dls_reg ? tx_sh_reg[7] : tx_sh_reg[6]);
    assign serial_clock_pin = active ? ckp_reg : cko_reg;
    assign serial_out_pin = (state_reg == CSM_SHIFT && txe_reg) ? out_bit : so_reg;
    assign serial_out_en = soe_reg;
    assign channel_transfer_irq = irq_reg;

    always_comb begin
        rd_next = 32'h0000_0000;
        case (addr)
            CSM_OFS_MODE: begin
                rd_next[CSM_B_OPSEL] = opsel_reg;
                rd_next[CSM_B_ISRC] = isrc_reg;
            end
            CSM_OFS_SETUP: begin
                rd_next[CSM_B_TXE] = txe_reg;
                rd_next[CSM_B_RXE] = rxe_reg;
                rd_next[CSM_B_DAP] = dap_reg;
                rd_next[CSM_B_CKP] = ckp_reg;
                rd_next[CSM_B_DIR] = dir_reg;
                rd_next[CSM_B_DLS] = dls_reg;
            end
            CSM_OFS_DATA: begin
                rd_next[15:CSM_B_DIV_LO] = div_reg;
                rd_next[7:0] = rx_data_reg;
            end
            CSM_OFS_OUTLVL: begin
                rd_next[CSM_B_CKO] = cko_reg;
                rd_next[CSM_B_SO] = so_reg;
            end
            CSM_OFS_STAT: begin
                rd_next[3:0] = {en_reg, ovf_reg, bff_reg, state_reg == CSM_SHIFT};
            end
            CSM_OFS_PRE: begin
                rd_next[7:0] = pre_reg;
            end
            CSM_OFS_OEN: begin
                rd_next[CSM_B_CH] = soe_reg;
            end
            default: begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            avs_readdata <= rd_next;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [3:0] smp_cnt;
    always_ff @(posedge mclk) begin
        if (srst || load) begin
            smp_cnt <= 4'h0;
        end else if (sample) begin
            smp_cnt <= smp_cnt + 4'h1;
        end
    end

    sequence s_word_end;
        done && !load;
    endsequence

    a_irq_single: assert property (@(posedge mclk) disable iff (srst)
        (done && !isrc_reg) |=> channel_transfer_irq)
        else $error("no transfer-end interrupt");
    a_irq_cont: assert property (@(posedge mclk) disable iff (srst)
        (load && isrc_reg) |=> channel_transfer_irq)
        else $error("no buffer-empty interrupt");
    a_word_bits: assert property (@(posedge mclk) disable iff (srst)
        done |-> (smp_cnt == (dls_reg ? 4'h8 : 4'h7)))
        else $error("wrong bit count");
    a_ovf_set: assert property (@(posedge mclk) disable iff (srst)
        (done && rxe_reg && unread_reg && !rd_data) |=> ovf_reg)
        else $error("overrun not flagged");
    a_rx_move: assert property (@(posedge mclk) disable iff (srst)
        (done && rxe_reg) |=> unread_reg
            && rx_data_reg == fix_rx($past(rx_sh_reg), dls_reg, dir_reg))
        else $error("word not moved");
    a_tx_replace: assert property (@(posedge mclk) disable iff (srst)
        wr_lo |=> bff_reg && tx_buf_reg == $past(avs_writedata[7:0]))
        else $error("pending data not replaced");
    a_clk_idle: assert property (@(posedge mclk) disable iff (srst)
        (state_reg == CSM_IDLE) |-> serial_clock_pin == cko_reg)
        else $error("clock not idle");
    a_rx_only_out: assert property (@(posedge mclk) disable iff (srst)
        !txe_reg |-> serial_out_pin == so_reg)
        else $error("output moved in receive");
    a_word_idle: assert property (@(posedge mclk) disable iff (srst)
        s_word_end |=> state_reg == CSM_IDLE && !active)
        else $error("clock runs after word");
    a_bus_wait: assert property (@(posedge mclk) disable iff (srst)
        ((avs_read || avs_write) && !ack_reg) |=> !avs_waitrequest)
        else $error("waitrequest held");
endmodule

`default_nettype wire

// >>> bench/csm_slave_model.sv
// Purpose: Serial slave model on the far side of the channel
// Assumes: Bench sets the mode inputs and calls clr after each setup change
// Notes: Between words the input line flips rather than hold its last bit, unless an early-phase word is queued
`timescale 1ns/1ps
`default_nettype none
module csm_slave_model (
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    input wire logic ckp,
    input wire logic dap,
    input wire logic lsb,
    input wire logic len8
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    logic [7:0] cur = 8'hFF;
    logic [7:0] got = 8'h00;
    int n = 0;
    initial miso = 1'b0;
    function automatic int ix(input int k);
        return lsb ? k : (len8 ? 7 : 6) - k;
    endfunction
    task automatic clr();
        n = 0;
        got = 8'h00;
        tx_q.delete();
        rx_q.delete();
    endtask
    task automatic send(input logic [7:0] b);
        tx_q.push_back(b);
        // Early data phase needs bit 0 before the clock moves
        if (dap && n == 0) miso = tx_q[0][ix(0)];
    endtask
    always @(sck) begin
        if (sck === ckp) begin
            if (n == 0) cur = (tx_q.size() > 0) ? tx_q.pop_front() : 8'hFF;
            if (dap) got[ix(n)] = mosi;
            else miso = cur[ix(n)];
        end else if (sck === !ckp) begin
            if (!dap) got[ix(n)] = mosi;
            n++;
            if (n == (len8 ? 8 : 7)) begin
                n = 0;
                rx_q.push_back(got);
                got = 8'h00;
                miso = (dap && tx_q.size() > 0) ? tx_q[0][ix(0)] : !miso;
            end else if (dap) begin
                miso = cur[ix(n)];
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_clocked_serial_master_rx_txrx.sv
// Purpose: Self-checking bench for the serial master channel
// Assumes: Bus answers after its own wait, slave model on the pins
// Notes: Half period kept short through prescaler and divider fields
`timescale 1ns/1ps
`default_nettype none
module tb_clocked_serial_master_rx_txrx
    import csm_pkg::*;
;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sck;
    logic mosi;
    logic mosi_en;
    logic miso;
    logic irq;
    logic ckp = 1'b0;
    logic dap = 1'b0;
    logic lsb = 1'b0;
    logic len8 = 1'b1;
    logic [31:0] exp_q[$];
    logic [31:0] r;
    logic [7:0] m;
    int num_errors = 0;
    int samples_checked = 0;
    int irq_cnt = 0;
    int run = 0;
    int last_run = 0;
    int out_tog = 0;
    int seed = 32'hD6FD2072;
    int i;
    int n0;
    int h;

    csm_channel uut (.mclk(mclk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .serial_clock_pin(sck), .serial_in_pin(miso),
        .serial_out_pin(mosi), .serial_out_en(mosi_en), .channel_transfer_irq(irq));
    csm_slave_model slv (.sck(sck), .mosi(mosi), .miso(miso), .ckp(ckp), .dap(dap),
        .lsb(lsb), .len8(len8));

    always #4 mclk = ~mclk;
    always @(mosi) out_tog++;

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // Pre-edge values, so the watcher never races the design's updates
    always @(posedge mclk) begin
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (sck === ckp) begin
            run <= run + 1;
        end else begin
            if (run != 0) last_run <= run;
            run <= 0;
        end
        if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, exp_q.pop_front());
    end
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        avs_address <= {1'b0, a};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 50) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wait_irq(input int n);
        int k;
        for (k = 0; k < 5000 && irq_cnt < n; k++) @(posedge mclk);
        if (irq_cnt < n) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        check(sck, 1'b1);
        check(mosi_en, 1'b0);
        check(irq, 1'b0);
        rd(CSM_OFS_OUTLVL, {23'h0, CSM_RST_CKO, 7'h0, CSM_RST_SO});
        rd(CSM_OFS_PRE, {24'h0, CSM_RST_PRE});
        rd(CSM_OFS_DATA, {24'h0, CSM_RST_DATA});
        rd(5'h1E, 32'h0);
        // Divider lane alone must not queue a word
        avs_byteenable <= 4'h2;
        wr(CSM_OFS_DATA, 32'h14FF);
        avs_byteenable <= 4'hF;
        rd(CSM_OFS_DATA, 32'h1400);
        rd(CSM_OFS_STAT, 32'h0);
        $display("test reset done");
        // Every length, order, phase and polarity, random rates and data
        for (i = 0; i < 16; i++) begin
            {ckp, dap, lsb, len8} = i[3:0];
            r = $random(seed);
            m = len8 ? 8'hFF : 8'h7F;
            wr(CSM_OFS_PRE, {24'h0, 2'b00, r[5:4], 2'b00, r[1:0]});
            wr(CSM_OFS_MODE, {16'h0, r[8], 15'h0});
            wr(CSM_OFS_SETUP, {16'h0, 2'b11, dap, ckp, 4'h0, lsb, 6'h0, len8});
            wr(CSM_OFS_OUTLVL, {23'h0, !ckp, 8'h01});
            wr(CSM_OFS_START, 32'h1);
            slv.clr();
            slv.send(r[31:24]);
            n0 = irq_cnt;
            wr(CSM_OFS_DATA, {20'h0, r[11:9], 1'b0, r[23:16]});
            wait_irq(n0 + 1);
            h = (1 << (r[8] ? r[5:4] : r[1:0])) * (r[11:9] + 1);
            check(last_run, h);
            rd(CSM_OFS_DATA, {20'h0, r[11:9], 1'b0, r[31:24] & m});
            check(slv.rx_q.pop_front(), r[23:16] & m);
            wr(CSM_OFS_STOP, 32'h1);
        end
        rd(CSM_OFS_STAT, 32'h0);
        $display("test formats done");
        // Continuous mode, pending byte replaced, mode switched mid-word
        {ckp, dap, lsb, len8} = 4'b0001;
        wr(CSM_OFS_PRE, 32'h0);
        wr(CSM_OFS_MODE, 32'h1);
        wr(CSM_OFS_SETUP, 32'hC001);
        wr(CSM_OFS_OUTLVL, 32'h101);
        wr(CSM_OFS_START, 32'h1);
        slv.clr();
        slv.send(8'h3C);
        slv.send(8'hC3);
        n0 = irq_cnt;
        wr(CSM_OFS_DATA, 32'h0A5A);
        wait_irq(n0 + 1);
        wr(CSM_OFS_DATA, 32'h0A11);
        wr(CSM_OFS_DATA, 32'h0AE7);
        wait_irq(n0 + 2);
        wr(CSM_OFS_MODE, 32'h0);
        wait_irq(n0 + 3);
        check(slv.rx_q.pop_front(), 32'h5A);
        check(slv.rx_q.pop_front(), 32'hE7);
        rd(CSM_OFS_STAT, 32'hC);
        wr(CSM_OFS_STAT, 32'h4);
        rd(CSM_OFS_DATA, 32'h0AC3);
        rd(CSM_OFS_STAT, 32'h8);
        check(irq_cnt - n0, 3);
        $display("test continuous done");
        // Receive only, dummy byte, data line must hold its level
        wr(CSM_OFS_SETUP, 32'h4001);
        wr(CSM_OFS_OUTLVL, 32'h100);
        slv.clr();
        slv.send(8'h96);
        @(posedge mclk);
        out_tog = 0;
        n0 = irq_cnt;
        wr(CSM_OFS_DATA, 32'h00FF);
        wait_irq(n0 + 1);
        check(out_tog, 0);
        check(mosi, 1'b0);
        check(mosi_en, 1'b0);
        rd(CSM_OFS_DATA, 32'h0096);
        wr(CSM_OFS_STOP, 32'h1);
        rd(CSM_OFS_STAT, 32'h0);
        $display("test receive done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
